/* File: sca_admit.sv */
// Purpose: Command admission, priority selection, status byte and sense data for one target.
// Assumes: Software loads the command block and condition word, then writes the start bit.
// Notes: Results appear one clock after the start write takes effect.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sca_regs.svh"

module sca_admit
  import sca_pkg::*;
#(
  parameter int ADDR_W = 8  // APB address width.
) (
  input wire logic CLOCK,  // 10 MHz clock.
  input wire logic RST_N,  // Synchronous reset, active low.
  input wire logic PSEL,  // APB select.
  input wire logic PENABLE,  // APB access phase.
  input wire logic PWRITE,  // APB write when high.
  input wire logic [ADDR_W-1:0] PADDR,  // APB byte address.
  input wire logic [31:0] PWDATA,  // APB write data.
  output logic [31:0] PRDATA,  // APB read data.
  output logic PREADY,  // APB ready.
  output logic PSLVERR,  // APB error for unmapped addresses.
  output logic [7:0] STATUS_BYTE,  // Last status byte sent.
  output logic STATUS_STB,  // One-cycle pulse with each status byte.
  output logic EXEC_STB,  // One-cycle pulse when a fill-write starts.
  output logic FILL_ALL  // Fill-write covers all remaining blocks.
);

  if (ADDR_W < 8) begin : g_addr_chk
    $error("ADDR_W must be at least 8");
  end

  logic [31:0] cdb_q [8];
  logic [31:0] ctrl_q, cond_q, reftag_q, apptag_q;
  logic go_q, pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] status_q, pdt_q;
  logic stb_q, exec_q, fill_q, sense_ok_q, ws32_q;
  logic [2:0] psel_q;
  sca_sense_t sense_q, pend_q;
  logic pend_valid_q;
  logic [7:0] pend_init_q;
  logic [63:0] lba_q;
  logic [31:0] count_q;

  // Byte view of the command block; a process keeps every byte tracking its word.
  logic [7:0] cdb_by [32];
  always_comb begin
    for (int k = 0; k < 32; k++) cdb_by[k] = cdb_q[k / 4][(k % 4) * 8 +: 8];
  end

  wire logic access = PSEL && PENABLE && !pready_q;
  wire logic wr = access && PWRITE;
  wire logic [7:0] off = PADDR[7:0];
  wire logic mapped = (PADDR[1:0] == 2'b00) && (off <= `SCA_COUNT_OFF) && (PADDR[ADDR_W-1:0] == 
    ADDR_W'(off));

  // Bus slave: one wait cycle, then ready with data or error.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access;
      pslverr_q <= access && !mapped;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      for (int i = 0; i < 8; i++) cdb_q[i] <= `SCA_RST_WORD;
      ctrl_q <= `SCA_RST_WORD;
      cond_q <= `SCA_RST_WORD;
      reftag_q <= `SCA_RST_WORD;
      apptag_q <= `SCA_RST_WORD;
      go_q <= 1'b0;
    end else begin
      go_q <= wr && mapped && off == `SCA_CTRL_OFF && PWDATA[`SCA_CTRL_GO];
      if (wr && mapped) begin
        if (off < `SCA_CTRL_OFF) cdb_q[off[4:2]] <= PWDATA;
        if (off == `SCA_CTRL_OFF) ctrl_q <= {PWDATA[31:1], 1'b0};
        if (off == `SCA_COND_OFF) cond_q <= PWDATA;
        if (off == `SCA_REFTAG_OFF) reftag_q <= PWDATA;
        if (off == `SCA_APPTAG_OFF) apptag_q <= PWDATA;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      prdata_q <= `SCA_RST_WORD;
    end else if (access && !PWRITE && mapped) begin
      if (off < `SCA_CTRL_OFF) prdata_q <= cdb_q[off[4:2]];
      else case (off)
        `SCA_CTRL_OFF: prdata_q <= ctrl_q;
        `SCA_COND_OFF: prdata_q <= cond_q;
        `SCA_REFTAG_OFF: prdata_q <= reftag_q;
        `SCA_APPTAG_OFF: prdata_q <= apptag_q;
        `SCA_STAT_OFF: prdata_q <= {8'h00, pdt_q, pend_valid_q, ws32_q, psel_q, fill_q,
          sense_ok_q, 1'b0, status_q};
        `SCA_SENSE_OFF: prdata_q <= {12'h000, sense_q};
        `SCA_LBALO_OFF: prdata_q <= lba_q[31:0];
        `SCA_LBAHI_OFF: prdata_q <= lba_q[63:32];
        `SCA_COUNT_OFF: prdata_q <= count_q;
        default: prdata_q <= `SCA_RST_WORD;
      endcase
    end else begin
      prdata_q <= `SCA_RST_WORD;
    end
  end

  // Decode of the loaded command block.
  wire logic [7:0] opcode = cdb_by[0];
  wire logic [7:0] lun = ctrl_q[`SCA_CTRL_LUN];
  wire logic [7:0] initiator = ctrl_q[`SCA_CTRL_INIT];
  wire logic lun_ok = (lun == 8'h00);
  wire logic is_fill16 = (opcode == SCA_OP_FILL16);
  wire logic is_var = (opcode == SCA_OP_VARLEN);
  wire logic var_hdr_ok = (cdb_by[7] == SCA_FILL32_ADD_LEN) &&
    ({cdb_by[8], cdb_by[9]} == SCA_FILL32_SVC);
  wire logic is_fill32 = is_var && var_hdr_ok;
  wire logic known_op = is_fill16 || is_var || opcode == SCA_OP_TEST_READY ||
    opcode == SCA_OP_REQ_SENSE || opcode == SCA_OP_INQUIRY ||
    opcode == SCA_OP_PREFETCH10 || opcode == SCA_OP_PREFETCH16;
  wire logic cdb_bad = (is_fill16 && cdb_by[14] != 8'h00) || (is_var && !var_hdr_ok);
  wire logic type_two = cond_q[`SCA_COND_PROTECTION_ENABLED] && cond_q[`SCA_COND_PTYPE] == `SCA_PTYPE_TWO;
  wire logic [31:0] exp_ref = {cdb_by[20], cdb_by[21], cdb_by[22], cdb_by[23]};
  wire logic ref_bad = (exp_ref != reftag_q);
  wire logic [15:0] exp_app = {cdb_by[24], cdb_by[25]};
  wire logic [15:0] app_mask = {cdb_by[26], cdb_by[27]};
  // Only masked bits take part, and only while the tag owner bit is set.
  wire logic app_bad = cond_q[`SCA_COND_APP_OWNER] &&
    (((exp_app ^ apptag_q[15:0]) & app_mask) != 16'h0000);
  wire logic [63:0] new_lba = is_fill32 ?
    {cdb_by[12], cdb_by[13], cdb_by[14], cdb_by[15],
    cdb_by[16], cdb_by[17], cdb_by[18], cdb_by[19]} :
    {cdb_by[2], cdb_by[3], cdb_by[4], cdb_by[5],
    cdb_by[6], cdb_by[7], cdb_by[8], cdb_by[9]};
  wire logic [31:0] new_count = is_fill32 ?
    {cdb_by[28], cdb_by[29], cdb_by[30], cdb_by[31]} :
    {cdb_by[10], cdb_by[11], cdb_by[12], cdb_by[13]};
  wire logic [2:0] new_psel = is_fill32 ? cdb_by[10][7:5] : cdb_by[1][7:5];

  sca_status_t st;
  sca_sense_t sn;
  logic do_exec;
  logic [7:0] pdt;

  // Fixed-priority admission; the first active condition wins.
  always_comb begin
    st = SCA_GOOD;
    sn = '0;
    do_exec = 1'b0;
    pdt = 8'h00;
    if (!lun_ok) begin
      if (opcode == SCA_OP_INQUIRY) begin
        pdt = SCA_UNKNOWN_PDT;
      end else if (opcode == SCA_OP_REQ_SENSE) begin
        sn = '{key: 4'h5, asc: 8'h25, ascq: 8'h00};
      end else begin
        st = SCA_CHECK;
        sn = '{key: 4'h5, asc: 8'h25, ascq: 8'h00};
      end
    end else if (cond_q[`SCA_COND_WRONG_CONN]) begin
      st = SCA_CHECK;
      sn = '{key: 4'hb, asc: 8'h4e, ascq: 8'h00};
    end else if (cond_q[`SCA_COND_UNIT_ATTN]) begin
      st = SCA_CHECK;
      sn = '{key: 4'h6, asc: 8'h29, ascq: 8'h00};
    end else if (cond_q[`SCA_COND_OTHER_BUSY] && !cond_q[`SCA_COND_DISC_PRIV]) begin
      st = SCA_BUSY;
    end else if (cond_q[`SCA_COND_QUEUE_FULL]) begin
      st = SCA_QUEUE_FULL;
    end else if (cond_q[`SCA_COND_DEFERRED]) begin
      st = SCA_CHECK;
      sn = '{key: 4'h4, asc: 8'h44, ascq: 8'h00};
    end else if (cond_q[`SCA_COND_NOT_READY]) begin
      st = SCA_CHECK;
      sn = '{key: 4'h2, asc: 8'h04, ascq: 8'h01};
    end else if (cond_q[`SCA_COND_RESERVED]) begin
      st = SCA_RESV_CONFLICT;
    end else if (!known_op) begin
      st = SCA_CHECK;
      sn = '{key: 4'h5, asc: 8'h20, ascq: 8'h00};
    end else if (cdb_bad) begin
      st = SCA_CHECK;
      sn = '{key: 4'h5, asc: 8'h24, ascq: 8'h00};
    end else if (is_fill32 && !type_two) begin
      st = SCA_CHECK;
      sn = '{key: 4'h5, asc: 8'h20, ascq: 8'h00};
    end else if (is_fill32 && ref_bad) begin
      st = SCA_CHECK;
      sn = '{key: 4'hb, asc: 8'h10, ascq: 8'h03};
    end else if (is_fill32 && app_bad) begin
      st = SCA_CHECK;
      sn = '{key: 4'hb, asc: 8'h10, ascq: 8'h02};
    end else begin
      if (opcode == SCA_OP_PREFETCH10 || opcode == SCA_OP_PREFETCH16) st = SCA_COND_MET;
      if (opcode == SCA_OP_REQ_SENSE && pend_valid_q) sn = pend_q;
      do_exec = is_fill16 || is_fill32;
    end
  end

  wire logic bus_err = cond_q[`SCA_COND_BUS_ERROR];
  wire logic report = go_q && !bus_err;

  // Status byte and returned sense for the command just admitted.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      status_q <= 8'h00;
      stb_q <= 1'b0;
      sense_q <= '0;
      sense_ok_q <= 1'b0;
      pdt_q <= 8'h00;
    end else begin
      stb_q <= report;
      if (report) begin
        status_q <= {2'b00, st[5:1], 1'b0};
        sense_q <= sn;
        // Sense is meaningless for busy, queue full and conflict answers.
        sense_ok_q <= (st == SCA_CHECK) || (st == SCA_GOOD && opcode == SCA_OP_REQ_SENSE);
        pdt_q <= pdt;
      end
    end
  end

  // Sense of the last check on the valid unit, held until its initiator gets an answer other than check.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pend_q <= '0;
      pend_valid_q <= 1'b0;
      pend_init_q <= 8'h00;
    end else if (report && lun_ok) begin
      if (st == SCA_CHECK) begin
        pend_q <= sn;
        pend_valid_q <= 1'b1;
        pend_init_q <= initiator;
      end else if (initiator == pend_init_q) begin
        pend_valid_q <= 1'b0;
      end
    end
  end

  // Hand-off of an admitted fill-write; invalid units never reach here.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      exec_q <= 1'b0;
      fill_q <= 1'b0;
      ws32_q <= 1'b0;
      psel_q <= 3'h0;
      lba_q <= 64'h0;
      count_q <= 32'h0;
    end else begin
      exec_q <= report && do_exec && lun_ok;
      if (report && do_exec && lun_ok) begin
        lba_q <= new_lba;
        count_q <= new_count;
        fill_q <= (new_count == 32'h0);
        ws32_q <= is_fill32;
        psel_q <= new_psel;
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign STATUS_BYTE = status_q;
  assign STATUS_STB = stb_q;
  assign EXEC_STB = exec_q;
  assign FILL_ALL = fill_q;

  status_layout_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    STATUS_STB |-> STATUS_BYTE[7:6] == 2'b00 && STATUS_BYTE[0] == 1'b0)
    else $error("status byte reserved bits not zero");

  no_intermediate_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    STATUS_STB |-> STATUS_BYTE != 8'h10 && STATUS_BYTE != 8'h14)
    else $error("intermediate status produced");

  bus_error_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    go_q && bus_err |=> !STATUS_STB && !EXEC_STB)
    else $error("status reported despite bus error");

  bad_unit_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    report && !lun_ok && opcode != SCA_OP_INQUIRY && opcode != SCA_OP_REQ_SENSE
    |=> STATUS_BYTE == 8'h02 && sense_q.asc == 8'h25 && !EXEC_STB)
    else $error("invalid unit not refused");

  bad_unit_query_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    report && !lun_ok && opcode == SCA_OP_INQUIRY |=> STATUS_BYTE == 8'h00 && pdt_q == 8'h7f)
    else $error("invalid unit query wrong");

  unit_isolate_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    go_q && !lun_ok |=> $stable(lba_q) && $stable(count_q) && $stable(pend_valid_q))
    else $error("invalid unit disturbed valid unit");

  busy_code_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    report && lun_ok && cond_q[3:0] == 4'b0100 && !cond_q[`SCA_COND_DISC_PRIV]
    |=> STATUS_BYTE == 8'h08)
    else $error("busy not reported");

  queue_full_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    report && lun_ok && cond_q[1:0] == 2'b00 && cond_q[`SCA_COND_QUEUE_FULL] &&
    !(cond_q[`SCA_COND_OTHER_BUSY] && !cond_q[`SCA_COND_DISC_PRIV])
    |=> STATUS_BYTE == 8'h28 && !sense_ok_q)
    else $error("queue full not reported");

  prot_type_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    EXEC_STB && ws32_q |-> $past(type_two))
    else $error("32-byte fill ran without type two protection");

  fill_all_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    EXEC_STB |-> FILL_ALL == (count_q == 32'h0))
    else $error("fill-all flag does not match count");

  exec_timing_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    report && lun_ok && is_fill16 && cond_q[6:0] == 7'h00 && !cdb_bad
    |=> EXEC_STB && STATUS_STB && STATUS_BYTE == 8'h00)
    else $error("16-byte fill not started");

endmodule : sca_admit
`default_nettype wire

/* File: sca_host.sv */
// Purpose: Initiator-side model that issues APB transfers to the admission block.
// Assumes: The slave ends every access with a PREADY pulse.
// Notes: After the time-zero defaults, signals change only by non-blocking assignment just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module sca_host (
  input wire logic CLOCK,  // Shared clock.
  output logic PSEL,  // APB select.
  output logic PENABLE,  // APB access phase.
  output logic PWRITE,  // APB direction.
  output logic [7:0] PADDR,  // APB byte address.
  output logic [31:0] PWDATA,  // APB write data.
  input wire logic [31:0] PRDATA,  // APB read data.
  input wire logic PREADY,  // APB ready.
  input wire logic PSLVERR  // APB error.
);
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
  end

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Released lines show the inverse so stale values are never mistaken for live ones.
    PADDR <= ~a;
    PWDATA <= ~d;
  endtask : xfer
endmodule : sca_host
`default_nettype wire

/* File: sca_pkg.sv */
// Purpose: Types shared by the admission block.
// Assumes: Status byte layout with the code in bits 5 down to 1.
// Notes: Only the codes this target can produce are listed.
package sca_pkg;

  typedef enum logic [7:0] {
    SCA_GOOD = 8'h00,
    SCA_CHECK = 8'h02,
    SCA_COND_MET = 8'h04,
    SCA_BUSY = 8'h08,
    SCA_RESV_CONFLICT = 8'h18,
    SCA_QUEUE_FULL = 8'h28
  } sca_status_t;

  typedef enum logic [7:0] {
    SCA_OP_TEST_READY = 8'h00,
    SCA_OP_REQ_SENSE = 8'h03,
    SCA_OP_INQUIRY = 8'h12,
    SCA_OP_PREFETCH10 = 8'h34,
    SCA_OP_PREFETCH16 = 8'h90,
    SCA_OP_FILL16 = 8'h93,
    SCA_OP_VARLEN = 8'h7f
  } sca_opcode_t;

  typedef struct packed {
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } sca_sense_t;

  localparam logic [7:0] SCA_FILL32_ADD_LEN = 8'h18;
  localparam logic [15:0] SCA_FILL32_SVC = 16'h000d;
  localparam logic [7:0] SCA_UNKNOWN_PDT = 8'h7f;

endpackage : sca_pkg

/* File: sca_regs.svh */
// Purpose: Register offsets, field positions and reset values of the admission block.
// Assumes: APB with 32-bit data; one aligned word per register.
// Notes: Byte addresses; the command block occupies eight words from offset zero.
`ifndef SCA_REGS_SVH
`define SCA_REGS_SVH

`define SCA_CDB_BASE 8'h00
`define SCA_CTRL_OFF 8'h20
`define SCA_COND_OFF 8'h24
`define SCA_REFTAG_OFF 8'h28
`define SCA_APPTAG_OFF 8'h2c
`define SCA_STAT_OFF 8'h30
`define SCA_SENSE_OFF 8'h34
`define SCA_LBALO_OFF 8'h38
`define SCA_LBAHI_OFF 8'h3c
`define SCA_COUNT_OFF 8'h40

`define SCA_CTRL_GO 0
`define SCA_CTRL_LUN 15:8
`define SCA_CTRL_INIT 23:16

`define SCA_COND_WRONG_CONN 0
`define SCA_COND_UNIT_ATTN 1
`define SCA_COND_OTHER_BUSY 2
`define SCA_COND_QUEUE_FULL 3
`define SCA_COND_DEFERRED 4
`define SCA_COND_NOT_READY 5
`define SCA_COND_RESERVED 6
`define SCA_COND_BUS_ERROR 7
`define SCA_COND_PROTECTION_ENABLED 8
`define SCA_COND_PTYPE 11:9
`define SCA_COND_APP_OWNER 12
`define SCA_COND_DISC_PRIV 13

`define SCA_RST_WORD 32'h0000_0000
`define SCA_PTYPE_TWO 3'h1

`endif

/* File: tb_scsi_cmd_admission_status.sv */
// Purpose: Self-checking bench for command admission, status byte and sense data.
// Assumes: Status and hand-off pulses appear in the cycle after the start write's ready.
// Notes: Each command block is loaded word by word, then started through the control word.
`timescale 1ns/1ps
`default_nettype none
module tb_scsi_cmd_admission_status;
  import sca_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, st_stb, ex_stb, fill_all, er;
  logic [7:0] paddr, st_byte, init_id;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] cdb [32];
  int error_cnt;
  int check_count;
  logic [31:0] pc [7] = '{32'h7f, 32'h7e, 32'h7c, 32'h207c, 32'h70, 32'h60, 32'h40};
  logic [7:0] ps [7] = '{SCA_CHECK, SCA_CHECK, SCA_BUSY, SCA_QUEUE_FULL, SCA_CHECK,
                         SCA_CHECK, SCA_RESV_CONFLICT};
  logic [20:0] pv [7] = '{21'h1b4e00, 21'h162900, 21'h0, 21'h0, 21'h144400, 21'h120401, 21'h0};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  sca_admit dut (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .STATUS_BYTE(st_byte), .STATUS_STB(st_stb), .EXEC_STB(ex_stb), .FILL_ALL(fill_all));
  sca_host host (.CLOCK(clk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rd, er);
    chk(what, exp, rd & m);
  endtask : rdc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, er);
  endtask : wr

  task automatic newcmd(input logic [7:0] opc);
    foreach (cdb[i]) cdb[i] = 8'h00;
    cdb[0] = opc;
  endtask : newcmd

  task automatic put4(input int at, input logic [31:0] v);
    for (int i = 0; i < 4; i++) cdb[at + i] = v[31 - 8 * i -: 8];
  endtask : put4

  task automatic run(input logic [7:0] lun, input logic [31:0] cond, input logic [7:0] st,
                     input logic stb, input logic ex);
    for (int k = 0; k < 8; k++) begin
      wr(8'(4 * k), {cdb[4 * k + 3], cdb[4 * k + 2], cdb[4 * k + 1], cdb[4 * k]});
    end
    wr(8'h24, cond);
    wr(8'h20, {8'h00, init_id, lun, 8'h01});
    #1;
    chk("status strobe", {31'h0, stb}, {31'h0, st_stb});
    chk("exec strobe", {31'h0, ex}, {31'h0, ex_stb});
    if (stb) chk("status byte", {24'h0, st}, {24'h0, st_byte});
  endtask : run

  task automatic sense(input logic [19:0] s, input logic v);
    rdc("sense data", 8'h34, 32'hfffff, {12'h0, s});
    rdc("sense valid", 8'h30, 32'h200, {22'h0, v, 9'h0});
  endtask : sense

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #1_000_000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    init_id = 8'h01;
    error_cnt = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc("stat after reset", 8'h30, '1, 32'h0);
    host.xfer(1'b0, 8'h44, 32'h0, rd, er);
    chk("unmapped error", 32'h1, {31'h0, er});
    newcmd(SCA_OP_FILL16);
    put4(2, 32'h01020304);
    put4(6, 32'h05060708);
    put4(10, 32'h00000100);
    run(8'h00, 32'h0, SCA_GOOD, 1'b1, 1'b1);
    rdc("lba low", 8'h38, '1, 32'h05060708);
    rdc("lba high", 8'h3c, '1, 32'h01020304);
    rdc("block count", 8'h40, '1, 32'h100);
    chk("fill all", 32'h0, {31'h0, fill_all});
    put4(10, 32'h0);
    run(8'h00, 32'h0, SCA_GOOD, 1'b1, 1'b1);
    chk("fill all", 32'h1, {31'h0, fill_all});
    foreach (pc[i]) begin
      run(8'h00, pc[i], ps[i], 1'b1, 1'b0);
      sense(pv[i][19:0], pv[i][20]);
    end
    run(8'h00, 32'hc0, SCA_GOOD, 1'b0, 1'b0);
    cdb[14] = 8'h01;
    run(8'h00, 32'h0, SCA_CHECK, 1'b1, 1'b0);
    sense(20'h52400, 1'b1);
    run(8'h80, 32'h7f, SCA_CHECK, 1'b1, 1'b0);
    sense(20'h52500, 1'b1);
    newcmd(8'hc5);
    run(8'h00, 32'h40, SCA_RESV_CONFLICT, 1'b1, 1'b0);
    run(8'h00, 32'h0, SCA_CHECK, 1'b1, 1'b0);
    sense(20'h52000, 1'b1);
    newcmd(SCA_OP_INQUIRY);
    run(8'h01, 32'h0, SCA_GOOD, 1'b1, 1'b0);
    rdc("query byte", 8'h30, 32'hff0000, 32'h7f0000);
    newcmd(SCA_OP_REQ_SENSE);
    run(8'h01, 32'h0, SCA_GOOD, 1'b1, 1'b0);
    rdc("sense data", 8'h34, 32'hfffff, 32'h52500);
    rdc("pending sense", 8'h30, 32'h8000, 32'h8000);
    init_id = 8'h02;
    newcmd(SCA_OP_PREFETCH10);
    run(8'h00, 32'h0, SCA_COND_MET, 1'b1, 1'b0);
    rdc("pending sense", 8'h30, 32'h8000, 32'h8000);
    init_id = 8'h01;
    newcmd(SCA_OP_PREFETCH16);
    run(8'h00, 32'h0, SCA_COND_MET, 1'b1, 1'b0);
    rdc("pending sense", 8'h30, 32'h8000, 32'h0);
    newcmd(SCA_OP_TEST_READY);
    run(8'h00, 32'h0, SCA_GOOD, 1'b1, 1'b0);
    newcmd(SCA_OP_VARLEN);
    cdb[7] = SCA_FILL32_ADD_LEN;
    cdb[9] = SCA_FILL32_SVC[7:0];
    cdb[10] = 8'h20;
    put4(12, 32'h0a0b0c0d);
    put4(16, 32'h10203040);
    put4(20, 32'h11223344);
    put4(24, 32'habcdff00);
    put4(28, 32'h1);
    wr(8'h28, 32'h11223344);
    wr(8'h2c, 32'habcd);
    run(8'h00, 32'h100, SCA_CHECK, 1'b1, 1'b0);
    sense(20'h52000, 1'b1);
    run(8'h00, 32'h200, SCA_CHECK, 1'b1, 1'b0);
    run(8'h00, 32'h300, SCA_GOOD, 1'b1, 1'b1);
    rdc("lba low", 8'h38, '1, 32'h10203040);
    rdc("wide form", 8'h30, 32'h7800, 32'h4800);
    wr(8'h28, 32'h11223345);
    run(8'h00, 32'h300, SCA_CHECK, 1'b1, 1'b0);
    sense(20'hb1003, 1'b1);
    wr(8'h28, 32'h11223344);
    wr(8'h2c, 32'habff);
    run(8'h00, 32'h1300, SCA_GOOD, 1'b1, 1'b1);
    wr(8'h2c, 32'haacd);
    run(8'h00, 32'h1300, SCA_CHECK, 1'b1, 1'b0);
    sense(20'hb1002, 1'b1);
    run(8'h00, 32'h300, SCA_GOOD, 1'b1, 1'b1);
    cdb[7] = 8'h17;
    run(8'h00, 32'h300, SCA_CHECK, 1'b1, 1'b0);
    sense(20'h52400, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("status byte after reset", 32'h0, {24'h0, st_byte});
    rdc("stat after reset", 8'h30, '1, 32'h0);
    report_and_stop();
  end
endmodule : tb_scsi_cmd_admission_status
`default_nettype wire
